//--- hw/bb_detach.sv
// Billboard detach control: two timeouts, descriptor bytes, attach sequencing.
// Assumes event inputs are one-cycle pulses from same-clock USB device logic;
// the enable pin is asynchronous and is synchronised here.
//
// Operation
// R1 - Alternate string request starts string timeout; the code starts it only in billboard mode while attached
// R2 - String timeout expiry detaches, reattaches default
// R3 - Timeout counts in 10 ms units
// R4 - 16-bit timeout, default 2000 gives 20 s
// R5 - Low byte at 413e, high at 413f
// R6 - Descriptor bytes software configurable
// R7 - Descriptor bytes reset to documented defaults
// R8 - Enable pin low: detach, reattach as billboard
// R9 - Address set starts separate 20 s timeout; the code starts it only in billboard mode while attached
// R10 - Either expiry detaches, reattaches standard function
// R11 - Detach stops and clears both timeouts
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module bb_detach (
    input wire logic core_clk_in, // Core clock
    input wire logic rst_in, // Sync reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic bb_enable_n_in, // Billboard enable pin, low active
    input wire logic addr_set_in, // Host set address pulse
    input wire logic alt_string_req_in, // Alternate string request pulse
    input wire logic [15:0] reg_addr_in, // Register address
    input wire logic [7:0] reg_wdata_in, // Write data
    input wire logic reg_wr_in, // Write strobe
    input wire logic reg_rd_in, // Read strobe
    output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
    output logic attach_out, // Function connected
    output logic bb_mode_out // Billboard descriptors selected
);
    typedef enum logic [1:0] {
        ST_ATTACHED = 2'b00,
        ST_DETACH = 2'b01,
        ST_REATTACH = 2'b10
    } seq_t;

    function automatic logic in_desc(input logic [15:0] a);
        return a >= bb_detach_pkg::ADDR_DESC_BASE &&
            a < bb_detach_pkg::ADDR_DESC_BASE + 16'(bb_detach_pkg::DESC_BYTES);
    endfunction

    logic pin_s1_q, pin_s2_q, pin_prev_q;
    logic [15:0] tmo_b_q, tmo_b_d, tmo_a_q, tmo_a_d;
    logic [7:0] desc_q [bb_detach_pkg::DESC_BYTES];
    logic [7:0] rdata_q, rdata_d;
    seq_t seq_q, seq_d;
    logic bb_q, bb_d, bb_next_q, bb_next_d;
    logic attach_q, attach_d;
    logic [4:0] hold_q, hold_d;
    logic exp_a, exp_b, run_a, run_b, clr_tmo, pin_fall;
    logic [5:0] desc_idx;

    assign desc_idx = 6'(reg_addr_in - bb_detach_pkg::ADDR_DESC_BASE);
    assign pin_fall = pin_prev_q & ~pin_s2_q;
    assign clr_tmo = (seq_q == ST_ATTACHED) && (exp_a || exp_b || pin_fall);

    tick_timer u_tmo_b (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .start_in(alt_string_req_in && bb_q && seq_q == ST_ATTACHED), // R1
        .clear_in(clr_tmo), // R11
        .limit_in(tmo_b_q), // R4
        .running_out(run_b),
        .expire_out(exp_b)
    );
    tick_timer u_tmo_a (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .start_in(addr_set_in && bb_q && seq_q == ST_ATTACHED), // R9
        .clear_in(clr_tmo),
        .limit_in(tmo_a_q),
        .running_out(run_a),
        .expire_out(exp_a)
    );

    // Register file
    always_comb
    begin
        tmo_b_d = tmo_b_q;
        tmo_a_d = tmo_a_q;
        rdata_d = 8'h00;
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                bb_detach_pkg::ADDR_TMO_B_LOW: tmo_b_d[7:0] = reg_wdata_in; // R5
                bb_detach_pkg::ADDR_TMO_B_HIGH: tmo_b_d[15:8] = reg_wdata_in; // R5
                bb_detach_pkg::ADDR_TMO_A_LOW: tmo_a_d[7:0] = reg_wdata_in;
                bb_detach_pkg::ADDR_TMO_A_HIGH: tmo_a_d[15:8] = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                bb_detach_pkg::ADDR_TMO_B_LOW: rdata_d = tmo_b_q[7:0];
                bb_detach_pkg::ADDR_TMO_B_HIGH: rdata_d = tmo_b_q[15:8];
                bb_detach_pkg::ADDR_TMO_A_LOW: rdata_d = tmo_a_q[7:0];
                bb_detach_pkg::ADDR_TMO_A_HIGH: rdata_d = tmo_a_q[15:8];
                bb_detach_pkg::ADDR_STATUS:
                begin
                    rdata_d[bb_detach_pkg::STAT_ATTACHED] = seq_q == ST_ATTACHED;
                    rdata_d[bb_detach_pkg::STAT_TMO_A_RUN] = run_a;
                    rdata_d[bb_detach_pkg::STAT_TMO_B_RUN] = run_b;
                    rdata_d[bb_detach_pkg::STAT_DETACHED] = seq_q == ST_DETACH;
                    rdata_d[bb_detach_pkg::STAT_BB_MODE] = bb_q;
                end
                default: rdata_d = in_desc(reg_addr_in) ? desc_q[desc_idx] : 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            tmo_b_q <= bb_detach_pkg::TIMEOUT_DEFAULT; // R4
            tmo_a_q <= bb_detach_pkg::TIMEOUT_DEFAULT; // R9
            rdata_q <= 8'h00;
        end
        else if (ce_in)
        begin
            tmo_b_q <= tmo_b_d;
            tmo_a_q <= tmo_a_d;
            rdata_q <= rdata_d;
        end
    end

    // Descriptor bytes; loop keeps the array out of one big case
    genvar gi;
    generate
        for (gi = 0; gi < bb_detach_pkg::DESC_BYTES; gi++)
        begin : g_desc
            logic [7:0] byte_d;
            always_comb
            begin
                byte_d = desc_q[gi];
                if (reg_wr_in && in_desc(reg_addr_in) && desc_idx == 6'(gi))
                    byte_d = reg_wdata_in; // R6
            end
            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                    desc_q[gi] <= bb_detach_pkg::desc_default(gi); // R7
                else if (ce_in)
                    desc_q[gi] <= byte_d;
            end
        end
    endgenerate

    // Attach sequencer; detach held long enough for the port to see it
    always_comb
    begin
        seq_d = seq_q;
        bb_d = bb_q;
        bb_next_d = bb_next_q;
        hold_d = hold_q;
        unique case (seq_q)
            ST_ATTACHED:
            begin
                if (pin_fall)
                begin
                    seq_d = ST_DETACH; // R8
                    bb_next_d = 1'b1;
                    hold_d = '0;
                end
                else if (exp_a || exp_b)
                begin
                    seq_d = ST_DETACH; // R10
                    bb_next_d = 1'b0;
                    hold_d = '0;
                end
            end
            ST_DETACH:
            begin
                hold_d = hold_q + 5'h01;
                if (hold_q == 5'(bb_detach_pkg::DETACH_CYCLES - 1))
                    seq_d = ST_REATTACH;
            end
            ST_REATTACH:
            begin
                bb_d = bb_next_q; // R2
                seq_d = ST_ATTACHED;
            end
            default: seq_d = ST_ATTACHED;
        endcase
        attach_d = seq_d == ST_ATTACHED;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_prev_q <= 1'b1;
            seq_q <= ST_ATTACHED;
            bb_q <= 1'b0;
            bb_next_q <= 1'b0;
            hold_q <= '0;
            attach_q <= 1'b1;
        end
        else if (ce_in)
        begin
            pin_s1_q <= bb_enable_n_in;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            seq_q <= seq_d;
            bb_q <= bb_d;
            bb_next_q <= bb_next_d;
            hold_q <= hold_d;
            attach_q <= attach_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign attach_out = attach_q;
    assign bb_mode_out = bb_q;
endmodule

//--- hw/bb_detach_pkg.sv
// Constants for the billboard detach timer block: register map, defaults, timing.
// Assumes a 125 MHz core clock and byte-wide register port.
package bb_detach_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] TIMEOUT_DEFAULT = 16'h07d0;
    localparam logic [15:0] ADDR_TMO_B_LOW = 16'h413e;
    localparam logic [15:0] ADDR_TMO_B_HIGH = 16'h413f;
    localparam logic [15:0] ADDR_TMO_A_LOW = 16'h4140;
    localparam logic [15:0] ADDR_TMO_A_HIGH = 16'h4141;
    localparam logic [15:0] ADDR_STATUS = 16'h4142;
    localparam logic [15:0] ADDR_DESC_BASE = 16'h4150;
    localparam int unsigned DESC_BYTES = 48;
    localparam int unsigned STAT_ATTACHED = 0;
    localparam int unsigned STAT_TMO_A_RUN = 1;
    localparam int unsigned STAT_TMO_B_RUN = 2;
    localparam int unsigned STAT_DETACHED = 3;
    localparam int unsigned STAT_BB_MODE = 4;
    localparam int unsigned DETACH_CYCLES = 16;
    function automatic logic [7:0] desc_default(input int unsigned idx);
        case (idx)
            3: return 8'h01;
            4: return 8'h01;
            7: return 8'h80;
            40: return 8'h10;
            41: return 8'h01;
            45: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
endpackage

//--- hw/tick_timer.sv
// Programmable timeout counter in 10 ms units.
// Assumes start and clear are one-cycle pulses on the core clock.
`timescale 1ns/100ps
module tick_timer (
    input wire logic core_clk_in, // Core clock
    input wire logic rst_in, // Sync reset
    input wire logic ce_in, // Clock enable
    input wire logic start_in, // Start pulse
    input wire logic clear_in, // Stop and clear
    input wire logic [15:0] limit_in, // Limit in ticks
    output logic running_out, // Counting
    output logic expire_out // One-cycle expiry
);
    logic [23:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic run_q, run_d, exp_q, exp_d;
    always_comb
    begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (clear_in)
        begin
            run_d = 1'b0; // R11
            pre_d = '0;
            cnt_d = '0;
        end
        else if (start_in)
        begin
            run_d = 1'b1; // R1
            pre_d = '0;
            cnt_d = '0;
        end
        else if (run_q)
        begin
            if (cnt_q >= limit_in)
            begin
                exp_d = 1'b1; // R2
                run_d = 1'b0;
            end
            else if (pre_q == 24'(bb_detach_pkg::TICK_CYCLES - 1))
            begin
                pre_d = '0;
                cnt_d = cnt_q + 16'h0001; // R3
            end
            else
                pre_d = pre_q + 24'h000001;
        end
    end
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pre_q <= '0;
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end
    assign running_out = run_q;
    assign expire_out = exp_q;
endmodule

//--- verif/host_model.sv
// Upstream host model: set-address and string-request events, enable pin.
// Assumes the core clock and one task call at a time.
`timescale 1ns/100ps
module host_model (
    input wire logic core_clk_in, // Core clock
    output logic addr_set_out, // Set-address pulse
    output logic string_req_out, // String request pulse
    output logic pin_n_out // Enable pin
);
    initial
    begin
        addr_set_out = 1'b0;
        string_req_out = 1'b0;
        pin_n_out = 1'b1;
    end
    task automatic pulse_addr();
        @(posedge core_clk_in) addr_set_out <= 1'b1;
        @(posedge core_clk_in) addr_set_out <= 1'b0;
    endtask
    task automatic pulse_str();
        @(posedge core_clk_in) string_req_out <= 1'b1;
        @(posedge core_clk_in) string_req_out <= 1'b0;
    endtask
    // Pin held until changed: the sync needs several cycles
    task automatic set_pin(input logic v);
        @(posedge core_clk_in) pin_n_out <= v;
    endtask
endmodule

//--- verif/bb_detach_sva.sv
// Port checker for the billboard detach block.
// Checks pause while ce_in is low; tracks the string timeout register itself.
`timescale 1ns/100ps
module bb_detach_chk (
    input wire logic core_clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic ce_in, // Enable
    input wire logic bb_enable_n_in, // Pin
    input wire logic addr_set_in, // Address set
    input wire logic alt_string_req_in, // String request
    input wire logic [15:0] reg_addr_in, // Address
    input wire logic [7:0] reg_wdata_in, // Write data
    input wire logic reg_wr_in, // Write strobe
    input wire logic reg_rd_in, // Read strobe
    input wire logic [7:0] reg_rdata_out, // Read data
    input wire logic attach_out, // Attached
    input wire logic bb_mode_out // Billboard mode
);
    logic [15:0] lim_q;
    logic [15:0] lim_d;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in || !ce_in);
    always_comb
    begin
        lim_d = lim_q;
        if (reg_wr_in && ce_in && reg_addr_in == 16'h413e)
            lim_d[7:0] = reg_wdata_in;
        if (reg_wr_in && ce_in && reg_addr_in == 16'h413f)
            lim_d[15:8] = reg_wdata_in;
    end
    always_ff @(posedge core_clk_in)
        lim_q <= rst_in ? 16'h07d0 : lim_d;
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    low_readback_a: assert property (reg_rd_in && reg_addr_in == 16'h413e |=> reg_rdata_out == $past(lim_q[7:0]))
        else $error("timeout low byte wrong");
    high_readback_a: assert property (reg_rd_in && reg_addr_in == 16'h413f |=> reg_rdata_out == $past(lim_q[15:8]))
        else $error("timeout high byte wrong");
    unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 16'h4000 |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    reset_out_a: assert property ($fell(rst_in) |-> attach_out && !bb_mode_out)
        else $error("outputs wrong after reset");
    detach_len_a: assert property ($fell(attach_out) |->
        !attach_out[*8] ##1 !attach_out[*8] ##1 !attach_out ##1 attach_out)
        else $error("detach length wrong");
    mode_hold_a: assert property ($changed(bb_mode_out) |-> !$past(attach_out))
        else $error("mode changed while attached");
    pin_detach_a: assert property ($fell(bb_enable_n_in) && attach_out |->
        ##[1:6] !attach_out ##[16:34] (attach_out && bb_mode_out))
        else $error("pin detach sequence wrong");
    str_expire_a: assert property (alt_string_req_in && attach_out && bb_mode_out && lim_q == 16'h0000 |->
        ##[1:6] !attach_out ##[16:34] (attach_out && !bb_mode_out))
        else $error("string timeout sequence wrong");
    cover property ($rose(bb_mode_out));
    cover property ($fell(bb_mode_out));
    cover property (reg_wr_in && reg_addr_in == 16'h413f);
endmodule
bind bb_detach bb_detach_chk chk (.core_clk_in, .rst_in, .ce_in, .bb_enable_n_in, .addr_set_in,
    .alt_string_req_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .attach_out, .bb_mode_out);

//--- verif/billboard_detach_timer_b_tb.sv
// Register and timeout tests for the billboard detach block.
// Assumes a host model for events; ce_in held high except during one write that must be dropped.
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module billboard_detach_timer_b_tb;
    logic core_clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in, attach_out, bb_mode_out;
    logic bb_enable_n_in, addr_set_in, alt_string_req_in;
    logic [15:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    int failures = 0;
    int checks_done = 0;
    host_model host (.core_clk_in, .addr_set_out(addr_set_in), .string_req_out(alt_string_req_in),
        .pin_n_out(bb_enable_n_in));
    bb_detach dut (.core_clk_in, .rst_in, .ce_in, .bb_enable_n_in, .addr_set_in, .alt_string_req_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .attach_out, .bb_mode_out);
    function automatic logic [7:0] desc_exp(input int i);
        case (i)
            3, 4, 41: return 8'h01;
            7: return 8'h80;
            40: return 8'h10;
            45: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK(reg_rdata_out & m, e)
    endtask
    // Bounded wait, so a stuck output fails instead of hanging
    task automatic wait_att(input logic v);
        int n;
        n = 0;
        while (attach_out !== v && n < 100)
        begin
            @(posedge core_clk_in);
            #1 n++;
        end
        `CHK(attach_out, v)
    endtask
    task automatic stop_test();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        failures++;
        stop_test();
    end
    initial
    begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 16'h0000;
        reg_wdata_in = 8'h00;
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd_chk(16'h413e, 8'hd0);
        rd_chk(16'h413f, 8'h07);
        rd_chk(16'h4140, 8'hd0);
        rd_chk(16'h4141, 8'h07);
        for (int i = 0; i < 48; i++)
            rd_chk(16'h4150 + 16'(i), desc_exp(i));
        $display("test defaults done");
        wr_reg(16'h413e, 8'h5a);
        wr_reg(16'h413f, 8'ha5);
        rd_chk(16'h413e, 8'h5a);
        rd_chk(16'h413f, 8'ha5);
        // Frozen clock enable must drop the write
        ce_in <= 1'b0;
        wr_reg(16'h413e, 8'h77);
        ce_in <= 1'b1;
        rd_chk(16'h413e, 8'h5a);
        wr_reg(16'h4153, 8'h3c);
        rd_chk(16'h4153, 8'h3c);
        wr_reg(16'h4000, 8'hff);
        rd_chk(16'h4000, 8'h00);
        $display("test registers done");
        wr_reg(16'h413e, 8'h00);
        wr_reg(16'h413f, 8'h00);
        host.pulse_str();
        repeat (10) @(posedge core_clk_in);
        #1 `CHK(attach_out, 1'b1)
        rd_chk(16'h4142, 8'h01);
        host.set_pin(1'b0);
        wait_att(1'b0);
        wait_att(1'b1);
        `CHK(bb_mode_out, 1'b1)
        host.pulse_addr();
        rd_chk(16'h4142, 8'h13);
        host.pulse_str();
        wait_att(1'b0);
        rd_chk(16'h4142, 8'h18);
        wait_att(1'b1);
        `CHK(bb_mode_out, 1'b0)
        $display("test string timeout done");
        host.set_pin(1'b1);
        repeat (4) @(posedge core_clk_in);
        host.set_pin(1'b0);
        wait_att(1'b0);
        wait_att(1'b1);
        wr_reg(16'h4141, 8'h00);
        wr_reg(16'h4140, 8'h01);
        host.pulse_addr();
        // One tick is 10 ms, so a few hundred cycles must not expire it
        repeat (200) @(posedge core_clk_in);
        rd_chk(16'h4142, 8'h13);
        `CHK(attach_out, 1'b1)
        wr_reg(16'h4140, 8'h00);
        wait_att(1'b0);
        wait_att(1'b1);
        `CHK(bb_mode_out, 1'b0)
        $display("test address timeout done");
        stop_test();
    end
endmodule
